// ===== bench/tchk_checker.sv
`timescale 1ns/10ps
// watches the register strobes and the open-drain interrupt line
module tchk_checker
(
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       rvalid,
  input wire logic       int_n_out,
  input wire logic       int_n_oe,
  input wire logic       int_n_line
);
  logic irq_en; // mirror of the completion interrupt enable

  // mirror follows writes on the same edge as the real register
  always_ff @(posedge clk)
  begin
    if (reset)
      irq_en <= 1'b0;
    else if (wr_en && addr == 8'h41)
      irq_en <= wdata[6];
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  rvalid_tie_a: assert property (rvalid == $past(rd_en))
    else $error("read answer not one cycle after strobe");
  ext_range_a: assert property (rd_en && addr == 8'h40 |=>
    $signed(rdata) <= 89 && $signed(rdata) >= -38)
    else $error("external temperature outside range");
  unmapped_a: assert property (rd_en && addr == 8'h55 |=>
    rdata == 8'h00) else $error("unmapped read not zero");
  stat_read_a: assert property (rd_en && addr == 8'h3a && int_n_oe
    |=> rdata == 8'h01) else $error("status misses completion");
  stat_clear_a: assert property (rd_en && addr == 8'h3a && int_n_oe
    |=> !int_n_oe) else $error("status read left pin low");
  irq_hold_a: assert property (int_n_oe && !rd_en && !wr_en
    |=> int_n_oe) else $error("interrupt dropped by itself");
  pin_drive_a: assert property (int_n_oe |-> !int_n_out)
    else $error("open-drain driver not low");
  pin_low_a: assert property (int_n_oe |-> !int_n_line)
    else $error("driven pin not low");
  pin_idle_a: assert property (!int_n_oe |-> int_n_line)
    else $error("released pin not high");
  irq_gate_a: assert property (!irq_en |-> !$rose(int_n_oe))
    else $error("interrupt raised while disabled");

  cover property ($rose(int_n_oe));
  cover property (rd_en && addr == 8'h3a && int_n_oe);
  cover property (wr_en && addr == 8'h40 && $signed(wdata) > 89);
endmodule

// ===== bench/tchk_tb_top.sv
`timescale 1ns/10ps
// drives the host user port and the sensor side of the device
module tchk_tb_top;
  localparam int CONV = 8; // short conversion keeps the run brief
  logic       clk;
  logic       reset = 1'b1;
  logic       req = 1'b0;
  logic       req_write = 1'b0;
  logic [7:0] req_addr = 8'h00;
  logic [7:0] req_wdata = 8'h00;
  logic       temp_done = 1'b0;
  logic [7:0] temp_value = 8'h00;
  logic [7:0] adc_sample = 8'h00;
  logic       ack;
  logic [7:0] ack_rdata;
  logic       irq;
  logic       conv_start;
  logic       conv_done;
  logic       conv_busy;
  logic       busy;
  logic [4:0] chan;
  logic       src_sel;
  logic [7:0] comp_temp;
  logic [7:0] code;
  logic [7:0] wv [8] = '{8'h59, 8'h5a, 8'h7f, 8'hda, 8'hd9, 8'h80,
                         8'h19, 8'he0};
  logic [7:0] ev [8] = '{8'h59, 8'h59, 8'h59, 8'hda, 8'hda, 8'hda,
                         8'h19, 8'he0};
  int         err_count = 0;
  int         cmp_count = 0;
  int         cycles = 0;
  int         cc = 0;
  int         run_len = 0;
  int         n_done = 0;
  int         i;

  tchk_if bus ();
  tchk_host u_tchk_host (.clk(clk), .reset(reset), .bus(bus), .req(req),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .ack(ack), .ack_rdata(ack_rdata), .busy(busy), .irq(irq));
  tchk_device #(.CONV_CYCLES(CONV)) u_tchk_device (.clk(clk),
    .reset(reset), .bus(bus), .temp_done(temp_done),
    .temp_value(temp_value), .adc_sample(adc_sample),
    .conv_start(conv_start), .conv_busy(conv_busy),
    .conv_done(conv_done),
    .led_check_channel(chan), .comp_source_select(src_sel),
    .comp_temp(comp_temp));
  tchk_checker u_tchk_checker (.clk(clk), .reset(reset),
    .wr_en(bus.wr_en), .rd_en(bus.rd_en), .addr(bus.addr),
    .wdata(bus.wdata), .rdata(bus.rdata), .rvalid(bus.rvalid),
    .int_n_out(bus.int_n_out), .int_n_oe(bus.int_n_oe),
    .int_n_line(bus.int_n_line));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // conversion length from start pulse, completions, hang limit
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    cc = conv_start ? 0 : cc + 1;
    run_len = conv_done ? cc : run_len;
    n_done = conv_done ? n_done + 1 : n_done;
    if (cycles == 3000)
    begin
      err_count++;
      close_out();
    end
  end

  task automatic chk8(input string nm, input logic [7:0] exp,
                      input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk1(input string nm, input logic exp, input logic got);
    chk8(nm, {7'h00, exp}, {7'h00, got});
  endtask

  // one write; waits until the register has surely taken it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= 1'b1;
    req_write <= 1'b1;
    req_addr <= a;
    req_wdata <= d;
    @(posedge clk);
    req <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                    input string nm);
    int k;
    @(posedge clk);
    req <= 1'b1;
    req_write <= 1'b0;
    req_addr <= a;
    @(posedge clk);
    req <= 1'b0;
    #1;
    chk1("host busy", 1'b1, busy);
    for (k = 0; k < 8 && ack !== 1'b1; k++)
    begin
      @(posedge clk);
      #1;
    end
    chk8(nm, exp, ack_rdata);
  endtask

  // start a conversion and wait, bounded, for its completion
  task automatic go_wait(input logic [7:0] ctl);
    int k;
    int d0;
    d0 = n_done;
    wr(8'h41, ctl);
    chk1("conv busy", 1'b1, conv_busy);
    for (k = 0; k < 40 && n_done == d0; k++)
      @(posedge clk);
    repeat (5) @(posedge clk); // pin to host irq crosses three flops
    #1;
    chk1("conv idle", 1'b0, conv_busy);
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk8("comp temp", tchk_pkg::INT_TEMP_RST, comp_temp);
    rd(8'h3f, 8'h19, "int temp");
    rd(8'h40, 8'h00, "ext temp");
    rd(8'h41, 8'h00, "led ctrl");
    rd(8'h55, 8'h00, "unmapped");
    wr(8'h3f, 8'h55);
    rd(8'h3f, 8'h19, "int temp ro");
    for (i = 0; i < 8; i++)
    begin
      wr(8'h40, wv[i]);
      rd(8'h40, ev[i], "ext clamp");
    end
    wr(8'h3e, 8'h01);
    chk8("comp ext", 8'he0, comp_temp);
    chk1("src sel", 1'b1, src_sel);
    wr(8'h3e, 8'h00);
    chk8("comp int", 8'h19, comp_temp);
    @(posedge clk);
    temp_value <= 8'hf0;
    temp_done <= 1'b1;
    @(posedge clk);
    temp_done <= 1'b0;
    temp_value <= 8'h0f; // a later value must not leak in
    rd(8'h3f, 8'hf0, "int temp upd");
    for (i = 0; i < 11; i++)
    begin
      code = (i < 9) ? 8'(i) : ((i == 9) ? 8'h0f : 8'h11);
      wr(8'h41, code);
      chk8("channel", code, {3'h0, chan});
    end
    @(posedge clk);
    adc_sample <= 8'ha6;
    go_wait(8'hc3);
    chk8("conv len", 8'(CONV), 8'(run_len));
    chk8("one conv", 8'h01, 8'(n_done));
    chk1("irq on", 1'b1, irq);
    rd(8'h42, 8'ha6, "result");
    rd(8'h41, 8'h43, "go clears");
    rd(8'h3a, 8'h01, "status");
    repeat (4) @(posedge clk);
    #1;
    chk1("irq off", 1'b0, irq);
    rd(8'h3a, 8'h00, "status clr");
    go_wait(8'h80);
    chk1("irq masked", 1'b0, irq);
    rd(8'h3a, 8'h00, "status masked");
    chk8("two conv", 8'h02, 8'(n_done));
    // reset in mid-run must bring back the documented reset values
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rd(8'h3f, 8'h19, "int temp rst");
    rd(8'h40, 8'h00, "ext temp rst");
    rd(8'h41, 8'h00, "led ctrl rst");
    chk8("comp rst", 8'h19, comp_temp);
    close_out();
  end
endmodule

// ===== verilog/tchk_device.sv
`timescale 1ns/10ps
// Summary of operation
// (R1) internal result read-only, resets to 25 degrees
// (R2) temperatures are 8-bit two's complement degrees
// (R3) written temperature clamped to -38..89 degrees
// (R4) external temperature register, read/write, resets zero
// (R5) writing convert bit one starts one conversion
// (R6) each led check conversion lasts 2.7 ms
// (R7) irq enable gates completion onto interrupt pin
// (R8) reading status register 0x3A clears pending interrupt
// (R9) source select picks internal or external temperature
// (R10) channel field bits 4:0 selects measured input
// (R11) conversion result held in read-only register 0x42
// (R12) internal result updated only on finished measurement
module tchk_device
#(
  parameter int CONV_CYCLES = tchk_pkg::LED_CONV_CYCLES
)
(
  input  wire logic                          clk,
  input  wire logic                          reset,
  tchk_if.device                             bus,
  input  wire logic                          temp_done,
  input  wire logic [tchk_pkg::DATA_W-1:0]   temp_value,
  input  wire logic [tchk_pkg::DATA_W-1:0]   adc_sample,
  output logic                               conv_start,
  output logic                               conv_busy,
  output logic                               conv_done,
  output logic      [tchk_pkg::CHAN_W-1:0]   led_check_channel,
  output logic                               comp_source_select,
  output logic      [tchk_pkg::DATA_W-1:0]   comp_temp
);

  localparam int CNT_W = $clog2(CONV_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(CONV_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  typedef struct packed {
    logic [tchk_pkg::DATA_W-1:0]   int_temp;
    logic [tchk_pkg::DATA_W-1:0]   ext_temp;
    logic                          comp_sel;
    logic                          go;
    logic                          irq_en;
    logic [tchk_pkg::CHAN_W-1:0]   chan;
    logic [tchk_pkg::DATA_W-1:0]   led_result;
    logic [CNT_W-1:0]              count;
    logic                          pending;
    logic [tchk_pkg::DATA_W-1:0]   rdata;
    logic                          rvalid;
    logic                          int_oe;
    logic                          start;
    logic                          done;
    logic [tchk_pkg::DATA_W-1:0]   comp;
  } tchk_dev_t;

  tchk_dev_t s;
  tchk_dev_t next_s;

  // saturate a written reading to the compensation range
  function automatic logic [tchk_pkg::DATA_W-1:0] clamp_temp
  (
    input logic [tchk_pkg::DATA_W-1:0] v
  );
    logic signed [tchk_pkg::DATA_W-1:0] sv;
    sv = signed'(v);
    if (sv > tchk_pkg::TEMP_MAX)
      clamp_temp = tchk_pkg::TEMP_MAX;
    else if (sv < tchk_pkg::TEMP_MIN)
      clamp_temp = tchk_pkg::TEMP_MIN;
    else
      clamp_temp = v;
  endfunction

  // register read mux; unmapped addresses read zero
  function automatic logic [tchk_pkg::DATA_W-1:0] read_mux
  (
    input tchk_dev_t                   st,
    input logic [tchk_pkg::ADDR_W-1:0] a
  );
    logic [tchk_pkg::DATA_W-1:0] d;
    d = tchk_pkg::READ_ZERO;
    case (a)
      tchk_pkg::ADDR_STATUS:
        d[tchk_pkg::STATUS_LED_BIT] = st.pending;
      tchk_pkg::ADDR_TEMP_CTRL:
        d[tchk_pkg::COMP_SEL_BIT] = st.comp_sel;
      tchk_pkg::ADDR_INT_TEMP:
        d = st.int_temp;
      tchk_pkg::ADDR_EXT_TEMP:
        d = st.ext_temp;
      tchk_pkg::ADDR_LED_CTRL:
      begin
        d[tchk_pkg::LED_GO_BIT]                  = st.go;
        d[tchk_pkg::LED_IRQ_EN_BIT]              = st.irq_en;
        d[tchk_pkg::CHAN_MSB:tchk_pkg::CHAN_LSB] = st.chan;
      end
      tchk_pkg::ADDR_LED_RESULT:
        d = st.led_result;
      default:
        d = tchk_pkg::READ_ZERO;
    endcase
    read_mux = d;
  endfunction

  logic wr_ctrl;
  logic wr_ext;
  logic wr_led;
  logic rd_status;
  logic finish;

  // address decode and end of conversion
  assign wr_ctrl   = bus.wr_en && (bus.addr == tchk_pkg::ADDR_TEMP_CTRL);
  assign wr_ext    = bus.wr_en && (bus.addr == tchk_pkg::ADDR_EXT_TEMP);
  assign wr_led    = bus.wr_en && (bus.addr == tchk_pkg::ADDR_LED_CTRL);
  assign rd_status = bus.rd_en && (bus.addr == tchk_pkg::ADDR_STATUS);
  assign finish    = s.go && (s.count == CNT_ZERO);

  // next-state logic for all registers and the conversion timer
  always_comb
  begin
    next_s        = s;
    next_s.start  = 1'b0;
    next_s.done   = 1'b0;
    next_s.rvalid = 1'b0;

    // internal result only moves on a finished measurement; the bus
    // has no write path to it, so host writes are dropped [R1] [R12]
    if (temp_done)
      next_s.int_temp = temp_value; // [R2]

    // external reading, clamped on the way in [R3] [R4]
    if (wr_ext)
      next_s.ext_temp = clamp_temp(bus.wdata);

    if (wr_ctrl)
      next_s.comp_sel = bus.wdata[tchk_pkg::COMP_SEL_BIT]; // [R9]

    // control fields; go cannot be cleared by software mid-conversion,
    // which keeps the analogue side from seeing a cut-short cycle
    if (wr_led)
    begin
      next_s.irq_en = bus.wdata[tchk_pkg::LED_IRQ_EN_BIT]; // [R7]
      next_s.chan   = bus.wdata[tchk_pkg::CHAN_MSB:tchk_pkg::CHAN_LSB]; // [R10]
      // one write of one, one conversion; ignored while busy [R5]
      if (bus.wdata[tchk_pkg::LED_GO_BIT] && !s.go)
      begin
        next_s.go    = 1'b1;
        next_s.start = 1'b1;
        next_s.count = CNT_LOAD; // [R6]
      end
    end

    // conversion timer counts down the fixed conversion time [R6]
    if (s.go && !finish)
      next_s.count = s.count - CNT_W'(1);

    // result capture and completion; go self-clears so that every
    // further conversion needs a new write of one [R5] [R11]
    if (finish)
    begin
      next_s.go         = 1'b0;
      next_s.done       = 1'b1;
      next_s.led_result = adc_sample;
    end

    // status read clears the pending flag, a same-cycle completion
    // wins over the clear so no event is lost [R8]
    if (rd_status)
      next_s.pending = 1'b0;
    if (finish && s.irq_en)
      next_s.pending = 1'b1; // [R7]

    // read data one cycle after the strobe
    if (bus.rd_en)
    begin
      next_s.rdata  = read_mux(s, bus.addr);
      next_s.rvalid = 1'b1;
    end

    // pin driven low only while pending and still enabled [R7]
    next_s.int_oe = next_s.pending && next_s.irq_en;

    // compensation source routing [R9]
    next_s.comp = next_s.comp_sel ? next_s.ext_temp : next_s.int_temp;
  end

  // state register; reset values come from the package
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s            <= '0;
      s.int_temp   <= tchk_pkg::INT_TEMP_RST; // [R1]
      s.ext_temp   <= tchk_pkg::EXT_TEMP_RST; // [R4]
      s.led_result <= tchk_pkg::LED_RESULT_RST;
      s.comp       <= tchk_pkg::INT_TEMP_RST;
    end
    else
      s <= next_s;
  end

  // outputs straight from the state register; int_n_out tied low
  assign bus.rdata          = s.rdata;
  assign bus.rvalid         = s.rvalid;
  assign bus.int_n_out      = 1'b0;
  assign bus.int_n_oe       = s.int_oe;
  assign conv_start         = s.start;
  assign conv_busy          = s.go;
  assign conv_done          = s.done;
  assign led_check_channel  = s.chan;
  assign comp_source_select = s.comp_sel;
  assign comp_temp          = s.comp;

endmodule

// ===== verilog/tchk_host.sv
`timescale 1ns/10ps
// host end: turns user requests into single register accesses
module tchk_host
(
  input  wire logic                          clk,
  input  wire logic                          reset,
  tchk_if.host                               bus,
  input  wire logic                          req,
  input  wire logic                          req_write,
  input  wire logic [tchk_pkg::ADDR_W-1:0]   req_addr,
  input  wire logic [tchk_pkg::DATA_W-1:0]   req_wdata,
  output logic                               ack,
  output logic      [tchk_pkg::DATA_W-1:0]   ack_rdata,
  output logic                               busy,
  output logic                               irq
);

  typedef enum logic [0:0] {TCHK_H_IDLE, TCHK_H_READ} tchk_hstate_t;

  typedef struct packed {
    tchk_hstate_t                  st;
    logic                          wr_en;
    logic                          rd_en;
    logic [tchk_pkg::ADDR_W-1:0]   addr;
    logic [tchk_pkg::DATA_W-1:0]   wdata;
    logic                          ack;
    logic [tchk_pkg::DATA_W-1:0]   ack_rdata;
    logic                          busy;
    logic                          int_s1;
    logic                          int_s2;
    logic                          irq;
  } tchk_host_t;

  tchk_host_t s;
  tchk_host_t next_s;

  // one access in flight; a read of the status register clears the
  // pending completion, so the user issues it to acknowledge [R8]
  always_comb
  begin
    next_s       = s;
    next_s.wr_en = 1'b0;
    next_s.rd_en = 1'b0;
    next_s.ack   = 1'b0;
    // interrupt line is a pin: three flops before the irq output
    next_s.int_s1 = ~bus.int_n_line;
    next_s.int_s2 = s.int_s1;
    next_s.irq    = s.int_s2;
    case (s.st)
      TCHK_H_IDLE:
      begin
        if (req)
        begin
          next_s.addr  = req_addr;
          next_s.wdata = req_wdata; // two's complement degrees [R2]
          next_s.busy  = 1'b1;
          if (req_write)
          begin
            next_s.wr_en = 1'b1; // external reading, convert go [R4] [R5]
            next_s.ack   = 1'b1;
            next_s.busy  = 1'b0;
          end
          else
          begin
            next_s.rd_en = 1'b1;
            next_s.st    = TCHK_H_READ;
          end
        end
      end
      TCHK_H_READ:
      begin
        if (bus.rvalid)
        begin
          next_s.ack       = 1'b1;
          next_s.ack_rdata = bus.rdata;
          next_s.busy      = 1'b0;
          next_s.st        = TCHK_H_IDLE;
        end
      end
      default:
        next_s.st = TCHK_H_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (reset)
      s <= '0;
    else
      s <= next_s;
  end

  assign bus.wr_en = s.wr_en;
  assign bus.rd_en = s.rd_en;
  assign bus.addr  = s.addr;
  assign bus.wdata = s.wdata;
  assign ack       = s.ack;
  assign ack_rdata = s.ack_rdata;
  assign busy      = s.busy;
  assign irq       = s.irq;

endmodule

// ===== verilog/tchk_if.sv
`timescale 1ns/10ps
// register access and interrupt line between host and device
interface tchk_if;
  logic                           wr_en;
  logic                           rd_en;
  logic [tchk_pkg::ADDR_W-1:0]    addr;
  logic [tchk_pkg::DATA_W-1:0]    wdata;
  logic [tchk_pkg::DATA_W-1:0]    rdata;
  logic                           rvalid;
  logic                           int_n_out;
  logic                           int_n_oe;
  logic                           int_n_line;

  // open-drain line: pulled high unless the device drives it
  assign int_n_line = int_n_oe ? int_n_out : 1'b1;

  modport device (
    input  wr_en,
    input  rd_en,
    input  addr,
    input  wdata,
    output rdata,
    output rvalid,
    output int_n_out,
    output int_n_oe,
    input  int_n_line
  );

  modport host (
    output wr_en,
    output rd_en,
    output addr,
    output wdata,
    input  rdata,
    input  rvalid,
    input  int_n_line
  );
endinterface

// ===== verilog/tchk_pkg.sv
package tchk_pkg;

  // bus and data widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int CHAN_W = 5;

  // register addresses on the control interface
  localparam logic [ADDR_W-1:0] ADDR_STATUS     = 8'h3a;
  localparam logic [ADDR_W-1:0] ADDR_TEMP_CTRL  = 8'h3e;
  localparam logic [ADDR_W-1:0] ADDR_INT_TEMP   = 8'h3f;
  localparam logic [ADDR_W-1:0] ADDR_EXT_TEMP   = 8'h40;
  localparam logic [ADDR_W-1:0] ADDR_LED_CTRL   = 8'h41;
  localparam logic [ADDR_W-1:0] ADDR_LED_RESULT = 8'h42;

  // reset values
  localparam logic [DATA_W-1:0] INT_TEMP_RST   = 8'h19;
  localparam logic [DATA_W-1:0] EXT_TEMP_RST   = 8'h00;
  localparam logic [DATA_W-1:0] LED_RESULT_RST = 8'h00;
  localparam logic [DATA_W-1:0] READ_ZERO      = 8'h00;

  // compensation range limits, two's complement whole degrees
  localparam logic signed [DATA_W-1:0] TEMP_MAX = 8'sh59;
  localparam logic signed [DATA_W-1:0] TEMP_MIN = 8'shda;

  // field positions
  localparam int LED_GO_BIT     = 7;
  localparam int LED_IRQ_EN_BIT = 6;
  localparam int CHAN_MSB       = 4;
  localparam int CHAN_LSB       = 0;
  localparam int COMP_SEL_BIT   = 0;
  localparam int STATUS_LED_BIT = 0;

  // timing
  localparam int CLK_PERIOD_NS    = 40;
  localparam int LED_CONV_TIME_NS = 2_700_000;
  localparam int LED_CONV_CYCLES  = LED_CONV_TIME_NS / CLK_PERIOD_NS;

endpackage
